/* File: verilog/lcdcd_consts.svh */
// constants of the lcd column driver core: instruction codes, status bits, timing
// assumes inclusion from the core design file and the package only
`ifndef LCDCD_CONSTS_SVH
`define LCDCD_CONSTS_SVH

// internal clock period and instruction execution time
`define LCDCD_CLK_NS 20
`define LCDCD_BUSY_NS 100
`define LCDCD_BUSY_CYC ((`LCDCD_BUSY_NS + `LCDCD_CLK_NS - 1) / `LCDCD_CLK_NS)

// instruction code fields
`define LCDCD_OP_DISP_ON 7'h1f
`define LCDCD_OP_SET_Y 2'h1
`define LCDCD_OP_SET_X 5'h17
`define LCDCD_OP_START 2'h3

// status byte bit positions
`define LCDCD_ST_BUSY 7
`define LCDCD_ST_ON 5
`define LCDCD_ST_RESET 4

// reset values
`define LCDCD_RST_ON 1'h0
`define LCDCD_RST_START 6'h00

// segment count and write buffer depth
`define LCDCD_NSEG 64
`define LCDCD_FIFO_DEPTH 4

`endif

/* File: verilog/lcdcd_pkg.sv */
// types shared by the lcd column driver core
// assumes lcdcd_consts.svh is reachable on the include path
`include "lcdcd_consts.svh"

package lcdcd_pkg;

  // drive level chosen for one segment output
  typedef enum logic [1:0] {
    LV_DRIVE_LEVEL_SELECT_A = 2'h0,
    LV_DRIVE_LEVEL_IDLE_A = 2'h1,
    LV_DRIVE_LEVEL_SELECT_B = 2'h2,
    LV_DRIVE_LEVEL_IDLE_B = 2'h3
  } lcdcd_level_t;

  // full state of the core except the write buffer, which lcdcd_fifo holds
  typedef struct packed {
    logic [511:0][7:0] ram;
    logic [7:0] in_reg;
    logic [7:0] out_reg;
    logic [7:0] dout;
    logic [7:0] snap_data;
    logic snap_sel;
    logic snap_di;
    logic snap_rw;
    logic [2:0] e_sync;
    logic cl_d;
    logic frm_d;
    logic disp_on;
    logic [5:0] start_line;
    logic [5:0] z;
    logic [2:0] x;
    logic [5:0] y;
    logic [2:0] busy_cnt;
    logic [63:0] latch;
    logic [63:0][1:0] seg;
  } lcdcd_core_t;

endpackage : lcdcd_pkg

/* File: verilog/lcdcd_core.sv */
// lcd column driver core: host port, input/output registers, busy flag,
// display ram, address counters, start line and segment level selection
// assumes clk_i is the internal clock built from the row driver's two-phase
// clock and that all inputs are synchronous to it

`include "lcdcd_consts.svh"

module lcdcd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // draining side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  // pointers carry one extra wrap bit so that full and empty differ
  function automatic logic [AW:0] ptr_inc(input logic [AW:0] p);
    return p + 1'b1;
  endfunction : ptr_inc

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } lcdcd_fifo_t;

  lcdcd_fifo_t s;
  lcdcd_fifo_t next_s;
  logic full;
  logic empty;

  // empty when both pointers agree, full when indices meet on opposite wraps
  // ready ignores a pop in the same cycle: one slot of throughput traded
  // for a short path from the draining side back to the filling side
  assign empty = (s.wr == s.rd);
  assign full = (s.wr[AW-1:0] == s.rd[AW-1:0]) && (s.wr[AW] != s.rd[AW]);
  assign in_ready_o = ~full;
  assign out_valid_o = ~empty;
  assign out_data_o = s.mem[s.rd[AW-1:0]];

  always_comb begin
    next_s = s;
    if (in_valid_i && !full) begin
      next_s.mem[s.wr[AW-1:0]] = in_data_i;
      next_s.wr = ptr_inc(s.wr);
    end
    if (out_ready_i && !empty) begin
      next_s.rd = ptr_inc(s.rd);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : lcdcd_fifo

module lcdcd_core
  import lcdcd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host port
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  input wire logic strobe_i,
  input wire logic data_instr_sel_i,
  input wire logic read_write_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic chip_select_c_i,
  // row driver side
  input wire logic frame_sync_i,
  input wire logic line_latch_strobe_i,
  input wire logic ac_polarity_i,
  // strap
  input wire logic segment_order_sel_i,
  // segment drive level selections
  output logic [63:0][1:0] segment_outputs_o
);

  lcdcd_core_t s;
  lcdcd_core_t next_s;

  logic sel;
  logic fall;
  logic cl_rise;
  logic busy;
  logic exec_busy;
  logic accept;
  logic wr_ev;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [16:0] fifo_out_data;
  logic [7:0] status;

  // level for one latched bit under the current polarity
  function automatic logic [1:0] level_of(input logic m, input logic d);
    lcdcd_level_t lv;
    if (m) begin
      lv = d ? LV_DRIVE_LEVEL_SELECT_A : LV_DRIVE_LEVEL_IDLE_A;
    end else begin
      lv = d ? LV_DRIVE_LEVEL_SELECT_B : LV_DRIVE_LEVEL_IDLE_B;
    end
    return lv;
  endfunction : level_of

  // byte address from page and column
  function automatic logic [8:0] ram_addr(input logic [2:0] page, input logic [5:0] col);
    return {page, col};
  endfunction : ram_addr

  // only the low, low, high pattern of the three selects opens the port
  function automatic logic host_selected(input logic a_n, input logic b_n, input logic c);
    return ~a_n & ~b_n & c;
  endfunction : host_selected

  // column counter step, wrapping from 63 to 0 by its width
  function automatic logic [5:0] col_inc(input logic [5:0] c);
    return c + 6'h1;
  endfunction : col_inc

  // ram column shown on segment output idx under the order strap
  function automatic logic [5:0] seg_col(input logic ord, input int idx);
    logic [5:0] c;
    c = 6'(idx);
    if (!ord) begin
      c = 6'(63 - idx);
    end
    return c;
  endfunction : seg_col

  // status byte: busy on bit 7, display on on bit 5, reset flag always clear
  function automatic logic [7:0] status_byte(input logic b, input logic on);
    logic [7:0] v;
    v = 8'h00;
    v[`LCDCD_ST_BUSY] = b;
    v[`LCDCD_ST_ON] = on;
    v[`LCDCD_ST_RESET] = 1'b0;
    return v;
  endfunction : status_byte

  // instruction patterns; any other byte is a no-op that still sets busy
  function automatic logic is_disp_on_op(input logic [7:0] d);
    return d[7:1] == `LCDCD_OP_DISP_ON;
  endfunction : is_disp_on_op

  function automatic logic is_set_y_op(input logic [7:0] d);
    return d[7:6] == `LCDCD_OP_SET_Y;
  endfunction : is_set_y_op

  function automatic logic is_set_x_op(input logic [7:0] d);
    return d[7:3] == `LCDCD_OP_SET_X;
  endfunction : is_set_x_op

  function automatic logic is_start_op(input logic [7:0] d);
    return d[7:6] == `LCDCD_OP_START;
  endfunction : is_start_op

  assign sel = host_selected(chip_select_a_n_i, chip_select_b_n_i, chip_select_c_i);
  // e_sync[0] feeds only e_sync[1]
  assign fall = s.e_sync[2] & ~s.e_sync[1];
  assign cl_rise = line_latch_strobe_i & ~s.cl_d;
  assign exec_busy = (s.busy_cnt != 3'h0);
  assign busy = exec_busy | fifo_out_valid;
  // writes go through the buffer; others wait for every pending write
  assign accept = s.snap_di && !s.snap_rw ? !exec_busy && fifo_in_ready : !busy;
  assign wr_ev = fall && s.snap_sel && s.snap_di && !s.snap_rw && accept;
  // ram write port yields to the display row fetch
  assign fifo_out_ready = ~cl_rise;

  // busy also covers buffered writes not yet in ram, so a read after a
  // burst of writes never overtakes them
  assign status = status_byte(busy, s.disp_on);

  lcdcd_fifo #(
    .WIDTH(17),
    .DEPTH(`LCDCD_FIFO_DEPTH)
  ) u_wbuf (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(wr_ev),
    .in_ready_o(fifo_in_ready),
    .in_data_i({ram_addr(s.x, s.y), s.snap_data}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(fifo_out_data)
  );

  always_comb begin
    logic [5:0] col;
    logic [8:0] a;
    col = 6'h00;
    a = 9'h000;
    next_s = s;
    next_s.e_sync = {s.e_sync[1:0], strobe_i};
    next_s.cl_d = line_latch_strobe_i;
    next_s.frm_d = frame_sync_i;
    // execution time counts down on every clock, whatever the host does
    if (exec_busy) begin
      next_s.busy_cnt = s.busy_cnt - 3'h1;
    end
    // bus sampled while the strobe is high, acted on after the synchronised fall
    if (strobe_i) begin
      next_s.snap_data = host_data_bus_i;
      next_s.snap_sel = sel;
      next_s.snap_di = data_instr_sel_i;
      next_s.snap_rw = read_write_i;
    end
    if (fall && s.snap_sel && accept) begin
      case ({s.snap_di, s.snap_rw})
        2'b10: begin
          // the byte itself travels through the buffer tagged with its address
          next_s.in_reg = s.snap_data;
          next_s.y = col_inc(s.y);
        end
        2'b11: begin
          // the host saw the old contents during this strobe; reload for the next
          next_s.out_reg = s.ram[ram_addr(s.x, s.y)];
          next_s.y = col_inc(s.y);
          next_s.busy_cnt = 3'(`LCDCD_BUSY_CYC);
        end
        2'b00: begin
          // out_reg left alone here, so a dummy read follows an address set
          // on/off touches only the flag, never the ram behind it
          if (is_disp_on_op(s.snap_data)) begin
            next_s.disp_on = s.snap_data[0];
          end else if (is_set_y_op(s.snap_data)) begin
            next_s.y = s.snap_data[5:0];
          end else if (is_set_x_op(s.snap_data)) begin
            next_s.x = s.snap_data[2:0];
          end else if (is_start_op(s.snap_data)) begin
            next_s.start_line = s.snap_data[5:0];
          end
          next_s.busy_cnt = 3'(`LCDCD_BUSY_CYC);
        end
        default: begin
        end
      endcase
    end
    // buffered display data into ram
    if (fifo_out_valid && fifo_out_ready) begin
      next_s.ram[fifo_out_data[16:8]] = fifo_out_data[7:0];
    end
    // display row fetch for the current line
    if (cl_rise) begin
      for (int i = 0; i < `LCDCD_NSEG; i++) begin
        col = 6'(i);
        a = ram_addr(s.z[5:3], col);
        next_s.latch[i] = s.ram[a][s.z[2:0]];
      end
      next_s.z = s.z + 6'h1;
    end
    // acts on level: while frame sync stays high the counter keeps its preset,
    // and a line strobe in that time cannot move the first row
    if (frame_sync_i) begin
      next_s.z = s.start_line;
    end
    // level selection with order mapping and display off forcing
    for (int i = 0; i < `LCDCD_NSEG; i++) begin
      col = seg_col(segment_order_sel_i, i);
      next_s.seg[i] = level_of(ac_polarity_i, s.latch[col] & s.disp_on);
    end
    // read data is registered; it settles one clock after the strobe rises,
    // so a host must not sample the bus in the first cycle of a read
    next_s.dout = s.snap_di ? s.out_reg : status;
    if (strobe_i) begin
      next_s.dout = data_instr_sel_i ? s.out_reg : status;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s <= '0;
      s.disp_on <= `LCDCD_RST_ON;
      s.start_line <= `LCDCD_RST_START;
      // segments leave reset at a non-select level, so the panel stays dark
      s.seg <= {`LCDCD_NSEG{LV_DRIVE_LEVEL_IDLE_B}};
    end else begin
      s <= next_s;
    end
  end

  assign host_data_bus_o = s.dout;
  // enable is combinational so the bus is released as soon as the strobe falls
  assign host_data_bus_oe_o = sel & read_write_i & strobe_i;
  assign segment_outputs_o = s.seg;

endmodule : lcdcd_core

/* File: tb/lcdcd_monitor.sv */
// checker of the host port and segment levels of lcdcd_core
// assumes it is bound onto lcdcd_core, one clock domain
module lcdcd_monitor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // host port
  input wire logic [7:0] host_data_bus_o,
  input wire logic host_data_bus_oe_o,
  input wire logic strobe_i,
  input wire logic data_instr_sel_i,
  input wire logic read_write_i,
  input wire logic chip_select_a_n_i,
  input wire logic chip_select_b_n_i,
  input wire logic chip_select_c_i,
  // segment side
  input wire logic ac_polarity_i,
  input wire logic [63:0][1:0] segment_outputs_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sel;
  logic seen;
  logic [63:0] hi;
  logic [63:0] lo;
  assign sel = !chip_select_a_n_i && !chip_select_b_n_i && chip_select_c_i;
  always_comb begin
    for (int i = 0; i < 64; i++) begin
      hi[i] = segment_outputs_o[i][1];
      lo[i] = segment_outputs_o[i][0];
    end
  end
  // set once an instruction write has been offered while selected
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen <= 1'b0;
    end else if (sel && strobe_i && !data_instr_sel_i && !read_write_i) begin
      seen <= 1'b1;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_drive_a:
    assert property (host_data_bus_oe_o == (sel && read_write_i && strobe_i)) else $error("bad oe");
  unsel_quiet_a:
    assert property (!sel |-> !host_data_bus_oe_o) else $error("unselected drive");
  seg_reset_a:
    assert property (disable iff (1'b0) rst_i |-> (hi & lo) == '1) else $error("seg reset");
  bus_reset_a:
    assert property (disable iff (1'b0) rst_i |-> host_data_bus_o == 8'h00) else $error("bus rst");
  pol_high_a:
    assert property (ac_polarity_i [*2] |-> hi == '0) else $error("level set a");
  pol_low_a:
    assert property (!ac_polarity_i [*2] |-> hi == '1) else $error("level set b");
  status_pad_a:
    assert property ((host_data_bus_oe_o && !data_instr_sel_i) [*3] |->
      (host_data_bus_o & 8'h5f) == 8'h00) else $error("status pad");
  dark_start_a:
    assert property (!seen |-> lo == '1) else $error("lit while off");
endmodule : lcdcd_monitor

/* File: tb/lcdcd_row_model.sv */
// row driver model: frame sync, line latch strobe and ac polarity
// assumes the bench calls its tasks; outputs change at falling edges
module lcdcd_row_model (
  input wire logic clk_i,
  output logic frame_sync_o,
  output logic line_latch_strobe_o,
  output logic ac_polarity_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    frame_sync_o = 1'b0;
    line_latch_strobe_o = 1'b0;
    ac_polarity_o = 1'b1;
  end
  task automatic set_pol(input logic p);
    @(negedge clk_i);
    ac_polarity_o = p;
  endtask : set_pol
  // optional frame start, then one clean line strobe pulse
  task automatic frame_line(input logic f);
    @(negedge clk_i);
    frame_sync_o = f;
    repeat (2) @(negedge clk_i);
    frame_sync_o = 1'b0;
    line_latch_strobe_o = 1'b1;
    repeat (2) @(negedge clk_i);
    line_latch_strobe_o = 1'b0;
    repeat (2) @(negedge clk_i);
  endtask : frame_line
endmodule : lcdcd_row_model

/* File: tb/tb_lcd_column_driver_core.sv */
// bench of lcdcd_core driven through its strobed host port
// assumes lcdcd_row_model as row driver and lcdcd_monitor bound below
module tb_lcd_column_driver_core
  import lcdcd_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rst_i = 1'b0;
  logic [7:0] hv = 8'h00;
  logic [7:0] bus_o;
  logic [7:0] bus_w;
  logic [7:0] q;
  logic oe;
  logic stb = 1'b0;
  logic di = 1'b0;
  logic rw = 1'b0;
  logic [2:0] cs = 3'h1;
  logic [2:0] bad [3] = '{3'h5, 3'h3, 3'h0};
  logic order = 1'b1;
  logic frame_sync;
  logic cl;
  logic pol;
  logic [63:0][1:0] seg;
  int error_cnt = 0;
  int compares = 0;
  always #10 clk_i = ~clk_i;
  // released host lines show the inverse of the device's last value
  assign bus_w = oe ? bus_o : (rw ? ~bus_o : hv);
  lcdcd_row_model ROW (.clk_i(clk_i), .frame_sync_o(frame_sync), .line_latch_strobe_o(cl),
    .ac_polarity_o(pol));
  lcdcd_core DUT (.clk_i(clk_i), .rst_i(rst_i), .host_data_bus_i(bus_w),
    .host_data_bus_o(bus_o), .host_data_bus_oe_o(oe), .strobe_i(stb),
    .data_instr_sel_i(di), .read_write_i(rw), .chip_select_a_n_i(cs[2]),
    .chip_select_b_n_i(cs[1]), .chip_select_c_i(cs[0]), .frame_sync_i(frame_sync),
    .line_latch_strobe_i(cl), .ac_polarity_i(pol), .segment_order_sel_i(order),
    .segment_outputs_o(seg));
  task automatic tally_and_finish();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk8
  task automatic chkl(input string n, input lcdcd_level_t e, input logic [1:0] g);
    chk8(n, {6'h00, e}, {6'h00, g});
  endtask : chkl
  task automatic access(input logic d, input logic r, input logic [7:0] v);
    @(negedge clk_i);
    di = d;
    rw = r;
    hv = v;
    stb = 1'b1;
    repeat (3) @(negedge clk_i);
    q = bus_w;
    stb = 1'b0;
    @(negedge clk_i);
  endtask : access
  task automatic ready();
    logic [7:0] keep;
    keep = q;
    for (int i = 0; i < 20; i++) begin
      access(1'b0, 1'b1, 8'h00);
      if (q[7] === 1'b0) begin
        q = keep;
        return;
      end
    end
    chk8("busy wait", 8'h00, q);
    tally_and_finish();
  endtask : ready
  task automatic op(input logic d, input logic r, input logic [7:0] v);
    access(d, r, v);
    ready();
  endtask : op
  initial begin
    // a real reset edge before the first clock, so no check sees unknowns
    #1;
    rst_i = 1'b1;
    repeat (6) @(negedge clk_i);
    rst_i = 1'b0;
    access(1'b0, 1'b1, 8'h00);
    chk8("status after reset", 8'h00, q);
    access(1'b0, 1'b0, 8'h3f);
    access(1'b0, 1'b1, 8'h00);
    chk8("status busy", 8'ha0, q);
    ready();
    access(1'b0, 1'b1, 8'h00);
    chk8("status on", 8'h20, q);
    op(1'b0, 1'b0, 8'hb8);
    op(1'b0, 1'b0, 8'h40);
    access(1'b1, 1'b0, 8'h3d);
    access(1'b1, 1'b0, 8'ha5);
    op(1'b0, 1'b0, 8'h40);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk8("read col0", 8'h3d, q);
    op(1'b1, 1'b1, 8'h00);
    chk8("read col1", 8'ha5, q);
    op(1'b0, 1'b0, 8'h7f);
    access(1'b1, 1'b0, 8'h11);
    access(1'b1, 1'b0, 8'h22);
    op(1'b0, 1'b0, 8'h7f);
    op(1'b1, 1'b1, 8'h00);
    op(1'b1, 1'b1, 8'h00);
    chk8("read col63", 8'h11, q);
    op(1'b1, 1'b1, 8'h00);
    chk8("read wrapped col0", 8'h22, q);
    foreach (bad[i]) begin
      cs = bad[i];
      access(1'b0, 1'b0, 8'h3e);
    end
    cs = 3'h1;
    access(1'b0, 1'b1, 8'h00);
    chk8("status after unselected", 8'h20, q);
    op(1'b0, 1'b0, 8'hc0);
    ROW.frame_line(1'b1);
    chkl("seg1", LV_DRIVE_LEVEL_SELECT_A, seg[1]);
    chkl("seg0", LV_DRIVE_LEVEL_IDLE_A, seg[0]);
    cs = 3'h0;
    order = 1'b0;
    repeat (2) @(negedge clk_i);
    cs = 3'h1;
    chkl("seg62 reversed", LV_DRIVE_LEVEL_SELECT_A, seg[62]);
    ROW.set_pol(1'b0);
    repeat (2) @(negedge clk_i);
    chkl("seg62 pol0", LV_DRIVE_LEVEL_SELECT_B, seg[62]);
    chkl("seg63 pol0", LV_DRIVE_LEVEL_IDLE_B, seg[63]);
    op(1'b0, 1'b0, 8'h3e);
    ROW.frame_line(1'b1);
    chkl("seg62 off", LV_DRIVE_LEVEL_IDLE_B, seg[62]);
    op(1'b0, 1'b0, 8'h3f);
    ROW.frame_line(1'b1);
    chkl("seg62 on again", LV_DRIVE_LEVEL_SELECT_B, seg[62]);
    op(1'b0, 1'b0, 8'hc1);
    ROW.frame_line(1'b1);
    chkl("seg62 scrolled", LV_DRIVE_LEVEL_IDLE_B, seg[62]);
    chkl("seg63 scrolled", LV_DRIVE_LEVEL_SELECT_B, seg[63]);
    tally_and_finish();
  end
endmodule : tb_lcd_column_driver_core

bind lcdcd_core lcdcd_monitor u_mon (.clk_i, .rst_i, .host_data_bus_o, .host_data_bus_oe_o,
  .strobe_i, .data_instr_sel_i, .read_write_i, .chip_select_a_n_i, .chip_select_b_n_i,
  .chip_select_c_i, .ac_polarity_i, .segment_outputs_o);
